//--- design/ssv_defs.svh
/*
 * Timing, field and reset constants of the stall, fault and power-mode
 * supervisor. Assumes REF_CLK at 200 MHz; times are in their own units.
 */
`ifndef SSV_DEFS_SVH
`define SSV_DEFS_SVH

// Clock period and time-to-cycle conversion, least times rounded up
`define SSV_CLK_NS 5
`define SSV_US2CYC(t) (((t) * 1000 + `SSV_CLK_NS - 1) / `SSV_CLK_NS)

// Sleep-input pulse and mode timing in microseconds
`define SSV_CLEAR_MIN_US 20
`define SSV_CLEAR_MAX_US 40
`define SSV_SLEEP_US 120
`define SSV_WAKE_US 100
`define SSV_OPEN_LOAD_US 10

// Stall-mode strap codes from the pin level decoder
`define SSV_STRAP_LOW 2'h0
`define SSV_STRAP_HIZ 2'h1
`define SSV_STRAP_HIGH 2'h2
`define SSV_STRAP_RES 2'h3

// Learning sample counts, count scaling and widths
`define SSV_STEADY_CYCLES 32
`define SSV_STALL_CYCLES 16
`define SSV_SCALE_SH 3
`define SSV_CNT_W 12
`define SSV_COILS 2

// Reset value of the learned stall threshold
`define SSV_TH_RST 0

`endif

//--- design/ssv_pkg.sv
/*
 * Types of the stall, fault and power-mode supervisor.
 * Assumes nothing of its surroundings.
 */
package ssv_pkg;

	// Stall-detection mode decoded from the strap
	typedef enum logic [1:0] {MODE_TORQUE, MODE_LEARN, MODE_THRESH,
		MODE_OFF} ssv_mode_t;

	// Power sequencing states
	typedef enum logic [1:0] {PWR_SLEEP, PWR_WAKE, PWR_RUN} ssv_pwr_t;

	// Learning progress
	typedef enum logic [1:0] {LRN_STEADY, LRN_STALL, LRN_DONE} ssv_lrn_t;

	// Controls toward the power stage
	typedef struct packed {
		logic sleep;
		logic pump_en;
		logic bridge_en;
		logic out_hiz;
	} ssv_drive_t;

	// Asynchronous pin and comparator levels
	typedef struct packed {
		logic       sleep_n;
		logic       en_hi;
		logic       en_flt;
		logic [1:0] strap;
		logic       rep;
		logic       uv;
		logic       hot;
		logic       ocp;
		logic       cpuv;
		logic [1:0] below_lim;
		logic [1:0] below_chop;
	} ssv_pins_t;

endpackage : ssv_pkg

//--- design/ssv_sleep_pulse.sv
/*
 * Sleep-input pulse classifier: times the low level of the sleep input,
 * flags a fault-clear pulse and a sleep request.
 * Assumes sleep_n is already synchronised to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssv_defs.svh"

module ssv_sleep_pulse
#(
	parameter int MIN_CYC   = `SSV_US2CYC(`SSV_CLEAR_MIN_US),
	parameter int SLEEP_CYC = `SSV_US2CYC(`SSV_SLEEP_US)
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic sleep_n,
	output var  logic clear_pulse,
	output var  logic sleep_req
);
	localparam int            CW    = $clog2(SLEEP_CYC + 1);
	localparam logic [CW-1:0] MIN_V = CW'(MIN_CYC);
	localparam logic [CW-1:0] SLP_V = CW'(SLEEP_CYC);

	logic [CW-1:0] low_cnt;
	logic [CW-1:0] next_low_cnt;
	logic          next_clear_pulse;
	logic          next_sleep_req;

	// Saturating low-time counter, restarted by every high level
	always_comb
	begin
		next_low_cnt     = '0;
		next_clear_pulse = 1'b0;
		next_sleep_req   = 1'b0;
		if (!sleep_n)
		begin
			if (low_cnt != SLP_V)
				next_low_cnt = low_cnt + 1'b1;
			else
				next_low_cnt = low_cnt;
			next_clear_pulse = (low_cnt == MIN_V);
			next_sleep_req   = (low_cnt == SLP_V);
		end
	end

	// Counter and flags
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			low_cnt     <= '0;
			clear_pulse <= 1'b0;
			sleep_req   <= 1'b0;
		end
		else
		begin
			low_cnt     <= next_low_cnt;
			clear_pulse <= next_clear_pulse;
			sleep_req   <= next_sleep_req;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Clear comes only once the low time passes the minimum
	clear_time_a: assert property (clear_pulse |-> low_cnt == MIN_V + 1'b1)
		else $error("clear pulse at wrong low time");

	// A low level shorter than the sleep delay never requests sleep
	short_low_a: assert property ($rose(sleep_n) && $past(low_cnt) != SLP_V
		|-> !sleep_req)
		else $error("short low level requested sleep");

	clear_seen_c: cover property (clear_pulse ##1 !sleep_req [*8]);

endmodule : ssv_sleep_pulse
`default_nettype wire

//--- design/ssv_supervisor.sv
/*
 * Stall-mode, fault-report and power-mode supervisor of a stepper driver:
 * strap decode, threshold learning, stall and open-load flags, thermal
 * reaction, sleep/disable/run sequencing and reset-pulse fault clearing.
 * Assumes pin-level decoders and analog comparators on the inputs, which
 * are synchronised here, and a torque-count engine on REF_CLK giving one
 * count per electrical cycle with TORQUE_VALID.
 */
// Functional notes
// - Learning mode: threshold out on torque pin, report high, low when learned.
// - Threshold-input mode: pin sets threshold; stall raises report and fault.
// - Resistor strap code: report held low, stalls ignored.
// - Winding below both limits past open-load time flags fault only.
// - Open-load stays latched until reset pulse, power cycle or wake.
// - Over-temperature: bridge and pump off, fault low, auto recovery.
// - Sleep entered, bridge and pump off, after delay from sleep low.
// - Wakes when sleep input high; controller waits the wake delay.
// - Sleep high, enable low: outputs off and high impedance, rest runs.
// - Active only with sleep high, enable high or floating, no undervoltage.
// - Sleep low between 20 and 40 us clears latched faults, no sleep.
// - Sleep low 40 to 120 us clears faults, shutdown not guaranteed.
// - Reset pulse leaves charge pump and other blocks untouched.
// - Any other fault disables stall detection.
// - Report line held low externally: no fault output on stall.
// - Enable floating scales torque count and threshold by eight.
// - Learned threshold is mean of steady and stalled counts.
`timescale 1ns/1ps
`default_nettype none
`include "ssv_defs.svh"

module ssv_supervisor
	import ssv_pkg::*;
#(
	parameter int CNT_W     = `SSV_CNT_W,
	parameter int SW        = CNT_W + `SSV_SCALE_SH,
	parameter int SLEEP_CYC = `SSV_US2CYC(`SSV_SLEEP_US),
	parameter int WAKE_CYC  = `SSV_US2CYC(`SSV_WAKE_US)
)
(
	input  wire logic             REF_CLK,
	input  wire logic             RST,
	input  wire logic             SLEEP_CTRL_N,
	input  wire logic             ENABLE_HIGH,
	input  wire logic             ENABLE_FLOAT,
	input  wire logic [1:0]       STALL_MODE_STRAP,
	input  wire logic             STALL_REPORT_I,
	input  wire logic             SUPPLY_UNDERVOLTAGE,
	input  wire logic             THERMAL_SHUTDOWN,
	input  wire logic             OVERCURRENT,
	input  wire logic             PUMP_UNDERVOLTAGE,
	input  wire logic [1:0]       COIL_BELOW_LIMIT,
	input  wire logic [1:0]       COIL_BELOW_CHOP,
	input  wire logic [CNT_W-1:0] TORQUE_COUNT,
	input  wire logic             TORQUE_VALID,
	input  wire logic [SW-1:0]    TORQUE_THRESHOLD_PIN_I,
	output var  logic             STALL_REPORT_O,
	output var  logic             STALL_REPORT_OE,
	output var  logic             FAULT_OUT_N_O,
	output var  logic             FAULT_OUT_N_OE,
	output var  logic [SW-1:0]    TORQUE_THRESHOLD_PIN_O,
	output var  logic             TORQUE_THRESHOLD_PIN_OE,
	output var  ssv_drive_t       DRIVE
);
	localparam int OPEN_CYC = `SSV_US2CYC(`SSV_OPEN_LOAD_US);
	localparam int OW       = $clog2(OPEN_CYC + 1);
	localparam int WW       = $clog2(WAKE_CYC + 1);
	localparam int LW       = $clog2(`SSV_STEADY_CYCLES);
	localparam int SUMW     = CNT_W + LW;
	localparam logic [OW-1:0] OPEN_V      = OW'(OPEN_CYC);
	localparam logic [WW-1:0] WAKE_V      = WW'(WAKE_CYC);
	localparam logic [LW-1:0] STEADY_LAST = LW'(`SSV_STEADY_CYCLES - 1);
	localparam logic [LW-1:0] STALL_LAST  = LW'(`SSV_STALL_CYCLES - 1);

	ssv_pins_t        pin_raw;
	ssv_pins_t        pin_s1;
	ssv_pins_t        s;
	logic             clr_pulse;
	logic             sleep_req;
	ssv_pwr_t         pwr;
	ssv_pwr_t         next_pwr;
	logic [WW-1:0]    wake_cnt;
	logic [WW-1:0]    next_wake_cnt;
	logic             wake_evt;
	logic             active;
	logic [OW-1:0]    open_cnt [`SSV_COILS];
	logic [OW-1:0]    next_open_cnt [`SSV_COILS];
	logic             open_load;
	logic             next_open_load;
	logic             open_hit;
	ssv_mode_t        mode;
	ssv_lrn_t         lrn;
	ssv_lrn_t         next_lrn;
	logic [LW-1:0]    lrn_cnt;
	logic [LW-1:0]    next_lrn_cnt;
	logic [SUMW-1:0]  lrn_sum;
	logic [SUMW-1:0]  next_lrn_sum;
	logic [SUMW-1:0]  lrn_add;
	logic [CNT_W-1:0] steady_avg;
	logic [CNT_W-1:0] next_steady_avg;
	logic [CNT_W-1:0] learned_th;
	logic [CNT_W-1:0] next_learned_th;
	logic             stall;
	logic             next_stall;
	logic             stall_hit;
	logic             other_fault;
	logic             sample;
	logic [SW-1:0]    cnt_s;
	logic [SW-1:0]    th_s;
	logic             rep_low;
	logic             fault;
	logic [SW-1:0]    next_tq_o;
	logic             next_tq_oe;
	ssv_drive_t       next_drive;

	// Strap code to stall-detection mode
	function automatic ssv_mode_t strap_mode(input logic [1:0] code);
		unique case (code)
			`SSV_STRAP_LOW:  strap_mode = MODE_TORQUE;
			`SSV_STRAP_HIZ:  strap_mode = MODE_LEARN;
			`SSV_STRAP_HIGH: strap_mode = MODE_THRESH;
			`SSV_STRAP_RES:  strap_mode = MODE_OFF;
		endcase
	endfunction : strap_mode

	// Count scaling while the enable pin floats
	function automatic logic [SW-1:0] scale(input logic [CNT_W-1:0] v,
		input logic flt);
		scale = flt ? {v, {`SSV_SCALE_SH{1'b0}}} : SW'(v);
	endfunction : scale

	// Mean of two counts without overflow
	function automatic logic [CNT_W-1:0] mid(input logic [CNT_W-1:0] a,
		input logic [CNT_W-1:0] b);
		logic [CNT_W:0] sum;
		sum = {1'b0, a} + {1'b0, b};
		mid = sum[CNT_W:1];
	endfunction : mid

	// Pin levels gathered for the synchroniser
	assign pin_raw = {SLEEP_CTRL_N, ENABLE_HIGH, ENABLE_FLOAT,
		STALL_MODE_STRAP, STALL_REPORT_I, SUPPLY_UNDERVOLTAGE,
		THERMAL_SHUTDOWN, OVERCURRENT, PUMP_UNDERVOLTAGE,
		COIL_BELOW_LIMIT, COIL_BELOW_CHOP};

	// Two-stage synchroniser for every pin input except TORQUE_THRESHOLD_PIN_I
	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			pin_s1 <= '0;
			s      <= '0;
		end
		else
		begin
			pin_s1 <= pin_raw;
			s      <= pin_s1;
		end
	end

	// Sleep-input low-time classifier
	ssv_sleep_pulse #(
		.MIN_CYC   (`SSV_US2CYC(`SSV_CLEAR_MIN_US)),
		.SLEEP_CYC (SLEEP_CYC)
	) u_sleep (
		.clk         (REF_CLK),
		.rst         (RST),
		.sleep_n     (s.sleep_n),
		.clear_pulse (clr_pulse),
		.sleep_req   (sleep_req)
	);

	// Sleep, wake and run sequencing
	always_comb
	begin
		next_pwr      = pwr;
		next_wake_cnt = '0;
		unique case (pwr)
			PWR_SLEEP:
				if (s.sleep_n)
					next_pwr = PWR_WAKE;
			PWR_WAKE:
				if (sleep_req)
					next_pwr = PWR_SLEEP;
				else if (wake_cnt == WAKE_V)
					next_pwr = PWR_RUN;
				else
					next_wake_cnt = wake_cnt + 1'b1;
			PWR_RUN:
				if (sleep_req)
					next_pwr = PWR_SLEEP;
			default:
				next_pwr = PWR_SLEEP;
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			pwr      <= PWR_SLEEP;
			wake_cnt <= '0;
		end
		else
		begin
			pwr      <= next_pwr;
			wake_cnt <= next_wake_cnt;
		end
	end

	assign wake_evt = (pwr == PWR_SLEEP) && s.sleep_n;

	// Open-load timers per winding and the latched flag
	always_comb
	begin
		open_hit = 1'b0;
		for (int i = 0; i < `SSV_COILS; i++)
		begin
			next_open_cnt[i] = '0;
			if (s.below_lim[i] && s.below_chop[i] && DRIVE.bridge_en)
			begin
				if (open_cnt[i] == OPEN_V)
				begin
					next_open_cnt[i] = open_cnt[i];
					open_hit         = 1'b1;
				end
				else
					next_open_cnt[i] = open_cnt[i] + 1'b1;
			end
		end
		next_open_load = open_hit ||
			(open_load && !clr_pulse && !wake_evt);
	end

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			open_cnt  <= '{default: '0};
			open_load <= 1'b0;
		end
		else
		begin
			open_cnt  <= next_open_cnt;
			open_load <= next_open_load;
		end
	end

	// Stall detection inputs
	assign mode        = strap_mode(s.strap);
	assign other_fault = s.uv | s.hot | s.ocp | s.cpuv | open_load;
	assign sample      = TORQUE_VALID && DRIVE.bridge_en && !other_fault;
	assign cnt_s       = scale(TORQUE_COUNT, s.en_flt);
	assign th_s        = (mode == MODE_THRESH) ? TORQUE_THRESHOLD_PIN_I
		: scale(learned_th, s.en_flt);
	assign stall_hit   = sample && cnt_s < th_s &&
		(mode == MODE_TORQUE || mode == MODE_THRESH);

	// Stall flag and threshold learning
	always_comb
	begin
		lrn_add         = lrn_sum + SUMW'(TORQUE_COUNT);
		next_lrn        = lrn;
		next_lrn_cnt    = lrn_cnt;
		next_lrn_sum    = lrn_sum;
		next_steady_avg = steady_avg;
		next_learned_th = learned_th;
		next_stall      = stall_hit || (stall && !clr_pulse);
		if (mode == MODE_OFF)
			next_stall = 1'b0;
		if (mode != MODE_LEARN)
		begin
			next_lrn     = LRN_STEADY;
			next_lrn_cnt = '0;
			next_lrn_sum = '0;
		end
		else if (sample)
		begin
			unique case (lrn)
				LRN_STEADY:
				begin
					next_lrn_cnt = lrn_cnt + 1'b1;
					next_lrn_sum = lrn_add;
					if (lrn_cnt == STEADY_LAST)
					begin
						next_steady_avg = CNT_W'(lrn_add >> LW);
						next_lrn        = LRN_STALL;
						next_lrn_cnt    = '0;
						next_lrn_sum    = '0;
					end
				end
				LRN_STALL:
				begin
					next_lrn_cnt = lrn_cnt + 1'b1;
					next_lrn_sum = lrn_add;
					if (TORQUE_COUNT >= steady_avg)
					begin
						next_lrn_cnt = '0;
						next_lrn_sum = '0;
					end
					else if (lrn_cnt == STALL_LAST)
					begin
						next_learned_th = mid(steady_avg,
							CNT_W'(lrn_add >> $clog2(`SSV_STALL_CYCLES)));
						next_lrn        = LRN_DONE;
					end
				end
				LRN_DONE:
					next_lrn = LRN_DONE;
				default:
					next_lrn = LRN_STEADY;
			endcase
		end
	end

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			lrn        <= LRN_STEADY;
			lrn_cnt    <= '0;
			lrn_sum    <= '0;
			steady_avg <= '0;
			learned_th <= CNT_W'(`SSV_TH_RST);
			stall      <= 1'b0;
		end
		else
		begin
			lrn        <= next_lrn;
			lrn_cnt    <= next_lrn_cnt;
			lrn_sum    <= next_lrn_sum;
			steady_avg <= next_steady_avg;
			learned_th <= next_learned_th;
			stall      <= next_stall;
		end
	end

	// Pin and power-stage output values
	always_comb
	begin
		next_tq_o  = TORQUE_THRESHOLD_PIN_O;
		next_tq_oe = 1'b0;
		rep_low    = !stall;
		unique case (mode)
			MODE_TORQUE:
			begin
				next_tq_oe = 1'b1;
				if (TORQUE_VALID)
					next_tq_o = cnt_s;
			end
			MODE_LEARN:
			begin
				rep_low    = (lrn == LRN_DONE);
				next_tq_oe = (lrn == LRN_DONE);
				next_tq_o  = scale(learned_th, s.en_flt);
			end
			MODE_THRESH:
				next_tq_oe = 1'b0;
			MODE_OFF:
				rep_low = 1'b1;
		endcase
		fault = s.uv | s.hot | s.ocp | s.cpuv | open_load |
			(stall && s.rep && (mode == MODE_TORQUE || mode == MODE_THRESH));
		active               = (pwr == PWR_RUN) && !s.uv &&
			(s.en_hi || s.en_flt);
		next_drive.bridge_en = active && !s.hot && !s.ocp && !s.cpuv;
		next_drive.out_hiz   = !next_drive.bridge_en;
		next_drive.pump_en   = (pwr != PWR_SLEEP) && !s.hot && !s.uv;
		next_drive.sleep     = (pwr == PWR_SLEEP);
	end

	always_ff @(posedge REF_CLK or posedge RST)
	begin
		if (RST)
		begin
			STALL_REPORT_O          <= 1'b1;
			STALL_REPORT_OE         <= 1'b0;
			FAULT_OUT_N_O           <= 1'b1;
			FAULT_OUT_N_OE          <= 1'b0;
			TORQUE_THRESHOLD_PIN_O  <= '0;
			TORQUE_THRESHOLD_PIN_OE <= 1'b0;
			DRIVE                   <= '{sleep: 1'b1, default: 1'b0};
		end
		else
		begin
			STALL_REPORT_O          <= !rep_low;
			STALL_REPORT_OE         <= rep_low;
			FAULT_OUT_N_O           <= !fault;
			FAULT_OUT_N_OE          <= fault;
			TORQUE_THRESHOLD_PIN_O  <= next_tq_o;
			TORQUE_THRESHOLD_PIN_OE <= next_tq_oe;
			DRIVE                   <= next_drive;
		end
	end

	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	learn_rep_a: assert property (mode == MODE_LEARN && lrn != LRN_DONE
		|=> !STALL_REPORT_OE && !TORQUE_THRESHOLD_PIN_OE)
		else $error("report pulled low before learning finished");

	off_rep_a: assert property (mode == MODE_OFF
		|=> STALL_REPORT_OE && !stall)
		else $error("disabled mode did not hold report low");

	hold_low_a: assert property (!s.rep && !other_fault
		|=> !FAULT_OUT_N_OE)
		else $error("fault driven with report held low");

	hot_off_a: assert property (s.hot
		|=> !DRIVE.bridge_en && !DRIVE.pump_en && FAULT_OUT_N_OE)
		else $error("over-temperature did not stop the stage");

	open_flag_a: assert property (open_hit && !s.hot && !s.ocp
		&& !s.cpuv |=> open_load ##1 !FAULT_OUT_N_O
		&& (DRIVE.bridge_en || $past(!active || s.hot || s.ocp || s.cpuv)))
		else $error("open load not reported or stopped the bridge");

	open_keep_a: assert property (open_load && !clr_pulse && !wake_evt
		|=> open_load)
		else $error("open load released without a clear");

	sleep_gate_a: assert property (pwr != PWR_SLEEP && !sleep_req
		|=> pwr != PWR_SLEEP)
		else $error("sleep entered without the delay");

	run_cond_a: assert property (DRIVE.bridge_en |-> $past(active))
		else $error("bridge on outside active conditions");

	disable_mode_a: assert property (pwr == PWR_RUN && !s.en_hi && !s.en_flt
		&& !s.hot && !s.uv |=> DRIVE.out_hiz && DRIVE.pump_en)
		else $error("disable mode stage state wrong");

	pump_keep_a: assert property (clr_pulse && pwr == PWR_RUN && !s.hot
		&& !s.uv |=> DRIVE.pump_en)
		else $error("reset pulse disturbed the charge pump");

	stall_gate_a: assert property (other_fault |-> !stall_hit)
		else $error("stall detected during another fault");

	count_scale_a: assert property (TORQUE_VALID && s.en_flt
		&& mode == MODE_TORQUE |=> TORQUE_THRESHOLD_PIN_O ==
		{$past(TORQUE_COUNT), {`SSV_SCALE_SH{1'b0}}})
		else $error("floating enable did not scale torque count");

	learn_done_c: cover property (lrn == LRN_STALL ##1 lrn == LRN_DONE);
	stall_fault_c: cover property (stall ##[1:8] !FAULT_OUT_N_O);
	wake_run_c: cover property (pwr == PWR_WAKE ##1 pwr == PWR_RUN);

endmodule : ssv_supervisor
`default_nettype wire

//--- tb/ssv_ctrl_model.sv
/*
 * Controller-side model: pulled-up stall report line with an optional
 * external pull-low, and a torque-count source, one count per cycle.
 * Assumes the report line is open-drain with a pull-up resistor.
 */
`timescale 1ns/1ps
`default_nettype none

module ssv_ctrl_model
(
	input  wire logic        clk,
	input  wire logic        rep_oe,
	input  wire logic        ext_low,
	output var  logic        rep_i,
	output var  logic        valid,
	output var  logic [11:0] count
);
	// Wired-AND line, pull-up when nobody pulls low
	assign rep_i = !(rep_oe || ext_low);

	initial
	begin
		valid = 1'b0;
		count = 12'h000;
	end

	// Electrical cycles eight clocks apart; count garbled between
	task automatic send(input logic [11:0] c, input int n);
		repeat (n)
		begin
			@(posedge clk);
			valid <= 1'b1;
			count <= c;
			@(posedge clk);
			valid <= 1'b0;
			count <= ~c;
			repeat (6) @(posedge clk);
		end
	endtask : send

endmodule : ssv_ctrl_model
`default_nettype wire

//--- tb/ssv_supervisor_tb.sv
/*
 * Self-checking bench of the stall, fault and power-mode supervisor.
 * Assumes ssv_ctrl_model as far side and a shortened sleep delay.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ssv_defs.svh"

module ssv_supervisor_tb
	import ssv_pkg::*;
;
	localparam int SLP = 5000;
	localparam int CLR = `SSV_US2CYC(`SSV_CLEAR_MIN_US);
	localparam int OLC = `SSV_US2CYC(`SSV_OPEN_LOAD_US);

	logic        REF_CLK, RST, SLEEP_CTRL_N, ENABLE_HIGH, ENABLE_FLOAT;
	logic        SUPPLY_UNDERVOLTAGE, THERMAL_SHUTDOWN, OVERCURRENT;
	logic        PUMP_UNDERVOLTAGE, STALL_REPORT_I, TORQUE_VALID, ext_low;
	logic [1:0]  STALL_MODE_STRAP, COIL_BELOW_LIMIT, COIL_BELOW_CHOP;
	logic [11:0] TORQUE_COUNT;
	logic [14:0] TORQUE_THRESHOLD_PIN_I, TORQUE_THRESHOLD_PIN_O;
	logic        STALL_REPORT_O, STALL_REPORT_OE, FAULT_OUT_N_O;
	logic        FAULT_OUT_N_OE, TORQUE_THRESHOLD_PIN_OE;
	ssv_drive_t  DRIVE;
	int          fail_count, n_tests;

	ssv_supervisor #(.SLEEP_CYC(SLP), .WAKE_CYC(10)) dut (
		.REF_CLK(REF_CLK), .RST(RST), .SLEEP_CTRL_N(SLEEP_CTRL_N),
		.ENABLE_HIGH(ENABLE_HIGH), .ENABLE_FLOAT(ENABLE_FLOAT),
		.STALL_MODE_STRAP(STALL_MODE_STRAP), .STALL_REPORT_I(STALL_REPORT_I),
		.SUPPLY_UNDERVOLTAGE(SUPPLY_UNDERVOLTAGE),
		.THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .OVERCURRENT(OVERCURRENT),
		.PUMP_UNDERVOLTAGE(PUMP_UNDERVOLTAGE),
		.COIL_BELOW_LIMIT(COIL_BELOW_LIMIT), .COIL_BELOW_CHOP(COIL_BELOW_CHOP),
		.TORQUE_COUNT(TORQUE_COUNT), .TORQUE_VALID(TORQUE_VALID),
		.TORQUE_THRESHOLD_PIN_I(TORQUE_THRESHOLD_PIN_I),
		.STALL_REPORT_O(STALL_REPORT_O), .STALL_REPORT_OE(STALL_REPORT_OE),
		.FAULT_OUT_N_O(FAULT_OUT_N_O), .FAULT_OUT_N_OE(FAULT_OUT_N_OE),
		.TORQUE_THRESHOLD_PIN_O(TORQUE_THRESHOLD_PIN_O),
		.TORQUE_THRESHOLD_PIN_OE(TORQUE_THRESHOLD_PIN_OE), .DRIVE(DRIVE));

	ssv_ctrl_model u_ctl (.clk(REF_CLK), .rep_oe(STALL_REPORT_OE),
		.ext_low(ext_low), .rep_i(STALL_REPORT_I), .valid(TORQUE_VALID),
		.count(TORQUE_COUNT));

	// 200 MHz clock
	initial
	begin
		REF_CLK = 1'b0;
		forever #2.5 REF_CLK = ~REF_CLK;
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Edge-aligned wait for driving; look settles after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge REF_CLK);
	endtask : tick

	task automatic look(input int n);
		tick(n);
		#1;
	endtask : look

	task automatic done(input string nm);
		$display("test %s finished", nm);
	endtask : done

	// Bounded wait: 0 fault, 1 bridge, 2 sleep
	task automatic wait_on(input int w, input logic v, input int lim);
		logic s;
		s = ~v;
		for (int i = 0; i < lim && s !== v; i++)
		begin
			look(1);
			s = (w == 0) ? FAULT_OUT_N_OE : (w == 1) ? DRIVE.bridge_en
				: DRIVE.sleep;
		end
		chk("wait", {15'h0, v}, {15'h0, s});
		if (s !== v)
			wrap_up();
	endtask : wait_on

	task automatic pulse(input int n);
		tick(1);
		SLEEP_CTRL_N <= 1'b0;
		tick(n);
		SLEEP_CTRL_N <= 1'b1;
	endtask : pulse

	initial
	begin
		{SLEEP_CTRL_N, ENABLE_HIGH, ENABLE_FLOAT, ext_low} = 4'h0;
		{SUPPLY_UNDERVOLTAGE, THERMAL_SHUTDOWN} = 2'h0;
		{OVERCURRENT, PUMP_UNDERVOLTAGE} = 2'h0;
		{COIL_BELOW_LIMIT, COIL_BELOW_CHOP} = 4'h0;
		STALL_MODE_STRAP = `SSV_STRAP_LOW;
		TORQUE_THRESHOLD_PIN_I = 15'h0000;
		fail_count = 0;
		n_tests = 0;
		RST = 1'b1;
		tick(20);
		RST <= 1'b0;
		look(3);
		chk("fault oe", 1'b0, FAULT_OUT_N_OE);
		chk("sleep", 1'b1, DRIVE.sleep);
		done("reset");
		// Wake, enable, then disable and back
		tick(1);
		SLEEP_CTRL_N <= 1'b1;
		ENABLE_HIGH <= 1'b1;
		wait_on(1, 1'b1, 100);
		chk("sleep", 1'b0, DRIVE.sleep);
		tick(1);
		ENABLE_HIGH <= 1'b0;
		wait_on(1, 1'b0, 20);
		look(2);
		chk("hiz", 1'b1, DRIVE.out_hiz);
		chk("pump", 1'b1, DRIVE.pump_en);
		tick(1);
		ENABLE_HIGH <= 1'b1;
		wait_on(1, 1'b1, 50);
		done("power");
		// Over-temperature with automatic recovery
		tick(1);
		THERMAL_SHUTDOWN <= 1'b1;
		wait_on(0, 1'b1, 20);
		look(1);
		chk("fault pin", 1'b0, FAULT_OUT_N_O);
		chk("bridge", 1'b0, DRIVE.bridge_en);
		chk("pump", 1'b0, DRIVE.pump_en);
		tick(1);
		THERMAL_SHUTDOWN <= 1'b0;
		wait_on(0, 1'b0, 20);
		wait_on(1, 1'b1, 50);
		// Undervoltage stops the bridge and reports, then recovers
		tick(1);
		SUPPLY_UNDERVOLTAGE <= 1'b1;
		wait_on(1, 1'b0, 20);
		chk("fault oe", 1'b1, FAULT_OUT_N_OE);
		tick(1);
		SUPPLY_UNDERVOLTAGE <= 1'b0;
		wait_on(1, 1'b1, 50);
		done("thermal");
		// Open load, latch, short and valid reset pulses
		tick(1);
		COIL_BELOW_LIMIT <= 2'h1;
		COIL_BELOW_CHOP <= 2'h1;
		look(OLC - 100);
		chk("fault oe", 1'b0, FAULT_OUT_N_OE);
		wait_on(0, 1'b1, 300);
		chk("bridge", 1'b1, DRIVE.bridge_en);
		tick(1);
		COIL_BELOW_LIMIT <= 2'h0;
		COIL_BELOW_CHOP <= 2'h0;
		look(50);
		chk("fault oe", 1'b1, FAULT_OUT_N_OE);
		pulse(CLR - 100);
		look(20);
		chk("fault oe", 1'b1, FAULT_OUT_N_OE);
		pulse(CLR + 500);
		wait_on(0, 1'b0, 50);
		chk("sleep", 1'b0, DRIVE.sleep);
		chk("pump", 1'b1, DRIVE.pump_en);
		done("open load");
		// Learning: steady then stalled samples
		tick(1);
		STALL_MODE_STRAP <= `SSV_STRAP_HIZ;
		look(5);
		chk("rep oe", 1'b0, STALL_REPORT_OE);
		u_ctl.send(12'h064, `SSV_STEADY_CYCLES);
		u_ctl.send(12'h014, `SSV_STALL_CYCLES);
		look(5);
		chk("rep oe", 1'b1, STALL_REPORT_OE);
		chk("rep o", 1'b0, STALL_REPORT_O);
		chk("pin", (16'h0064 + 16'h0014) >> 1, TORQUE_THRESHOLD_PIN_O);
		chk("pin oe", 1'b1, TORQUE_THRESHOLD_PIN_OE);
		done("learning");
		// Torque mode with floating enable scales the count
		tick(1);
		STALL_MODE_STRAP <= `SSV_STRAP_LOW;
		ENABLE_HIGH <= 1'b0;
		ENABLE_FLOAT <= 1'b1;
		u_ctl.send(12'h064, 2);
		look(3);
		chk("pin", 16'h0064 << `SSV_SCALE_SH, TORQUE_THRESHOLD_PIN_O);
		tick(1);
		ENABLE_HIGH <= 1'b1;
		ENABLE_FLOAT <= 1'b0;
		u_ctl.send(12'h050, 2);
		pulse(CLR + 500);
		look(20);
		chk("fault oe", 1'b0, FAULT_OUT_N_OE);
		chk("rep oe", 1'b1, STALL_REPORT_OE);
		done("torque");
		// Threshold input, stall with line held low, then released
		tick(1);
		TORQUE_THRESHOLD_PIN_I <= 15'h0032;
		STALL_MODE_STRAP <= `SSV_STRAP_HIGH;
		u_ctl.send(12'h050, 2);
		look(3);
		chk("rep oe", 1'b1, STALL_REPORT_OE);
		chk("pin oe", 1'b0, TORQUE_THRESHOLD_PIN_OE);
		tick(1);
		ext_low <= 1'b1;
		u_ctl.send(12'h01E, 2);
		look(5);
		chk("rep oe", 1'b0, STALL_REPORT_OE);
		chk("fault oe", 1'b0, FAULT_OUT_N_OE);
		chk("rep o", 1'b1, STALL_REPORT_O);
		tick(1);
		ext_low <= 1'b0;
		wait_on(0, 1'b1, 20);
		done("threshold");
		// Stall detection off by resistor strap
		tick(1);
		STALL_MODE_STRAP <= `SSV_STRAP_RES;
		u_ctl.send(12'h00A, 2);
		look(10);
		chk("rep oe", 1'b1, STALL_REPORT_OE);
		chk("fault oe", 1'b0, FAULT_OUT_N_OE);
		done("off");
		// Long low enters sleep only after the delay
		tick(1);
		SLEEP_CTRL_N <= 1'b0;
		look(SLP - 200);
		chk("sleep", 1'b0, DRIVE.sleep);
		wait_on(2, 1'b1, 400);
		chk("pump", 1'b0, DRIVE.pump_en);
		chk("bridge", 1'b0, DRIVE.bridge_en);
		done("sleep");
		wrap_up();
	end

endmodule : ssv_supervisor_tb
`default_nettype wire
